// >>> pkg/sliu_pkg.sv
// constants and types shared by the single-level interrupt unit
package sliu_pkg;

	// ****************************************
	// clock and request rate
	// ****************************************
	localparam int unsigned SLIU_CLK_HZ = 25_000_000;
	localparam int unsigned SLIU_IRQ_RATE_HZ = 32768;
	// rounded down: nominal rate only, the period is a little short
	localparam int unsigned SLIU_DIV_CYCLES = SLIU_CLK_HZ / SLIU_IRQ_RATE_HZ;
	localparam int SLIU_DIV_W = 10;
	localparam logic [9:0] SLIU_DIV_LAST = 10'(SLIU_DIV_CYCLES - 1);
	localparam logic [9:0] SLIU_DIV_RST = 10'h000;

	// ****************************************
	// widths and vector
	// ****************************************
	localparam int SLIU_PC_W = 13;
	localparam int SLIU_NIB_W = 4;
	localparam int SLIU_ADDR_W = 5;
	localparam logic [12:0] SLIU_IRQ_ENTRY = 13'h0008;

	// ****************************************
	// register offsets
	// ****************************************
	localparam logic [4:0] SLIU_OFS_STATUS = 5'h00;
	localparam logic [4:0] SLIU_OFS_CTRL = 5'h09;
	localparam logic [4:0] SLIU_OFS_EVT_STS = 5'h15;
	localparam logic [4:0] SLIU_OFS_EVT_MASK = 5'h16;

	// ****************************************
	// field positions
	// ****************************************
	localparam int SLIU_ST_ZERO = 0;
	localparam int SLIU_ST_CARRY = 1;
	localparam int SLIU_ST_FLAG = 2;
	localparam int SLIU_CT_PWM_EN = 0;
	localparam int SLIU_CT_GIE = 1;
	localparam int SLIU_EV_REQ = 0;
	localparam int SLIU_EV_TAKEN = 1;
	localparam int SLIU_EV_W = 2;

	// ****************************************
	// reset values
	// ****************************************
	localparam logic SLIU_RST_FLAG = 1'b0;
	localparam logic SLIU_RST_CARRY = 1'b0;
	localparam logic SLIU_RST_ZERO = 1'b0;
	localparam logic SLIU_RST_GIE = 1'b0;
	localparam logic SLIU_RST_PWM_EN = 1'b0;
	localparam logic [1:0] SLIU_RST_EVT = 2'h0;
	localparam logic [3:0] SLIU_RST_NIB = 4'h0;
	localparam logic [22:0] SLIU_RST_CTX = 23'h00_0000;

	// ****************************************
	// service state
	// ****************************************
	typedef enum logic [0:0] {
		SLIU_IDLE = 1'b0,
		SLIU_SERVICE = 1'b1
	} sliu_state_t;

endpackage

// >>> design/sliu_ctx_store.sv
// hidden save registers holding the interrupted context
`timescale 1ns/1ps
`default_nettype none

module sliu_ctx_store
	import sliu_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire logic ce,
	input wire logic wr_en,
	input wire logic [22:0] wr_data,
	output logic [22:0] rd_data
);

	typedef struct packed {
		logic [22:0] word;
	} sliu_ctx_t;

	sliu_ctx_t s_r;
	sliu_ctx_t s_nxt;

	// ****************************************
	// one word only: a single nesting level
	// ****************************************
	always_comb begin
		s_nxt = s_r;
		if (wr_en) begin
			s_nxt.word = wr_data;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			s_r.word <= SLIU_RST_CTX;
		end else if (ce) begin
			s_r <= s_nxt;
		end
	end

	assign rd_data = s_r.word;

endmodule

`default_nettype wire

// >>> design/sliu_top.sv
// single-source single-level interrupt unit with its flag and control registers
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// R1: there is one interrupt entry and acceptance loads the program counter with 0x008.
// R2: requests come nominally at 32768 Hz while the pulse output runs.
// R3: with the global enable high and the request flag set, the interrupt is taken on the next clock, never with the enable low.
// R4: on acceptance the next program counter, page high, memory address high, carry and zero are saved in hidden registers.
// R5: the context save and the entry load finish in one clock.
// R6: entering service clears the global enable in hardware.
// R7: acceptance leaves the request flag set.
// R8: the service routine must clear the request flag itself before interrupts are enabled again.
// R9: the interrupt return restores program counter, page high, memory address high, carry and zero.
// R10: the interrupt return sets the global enable again.
// R11: a subroutine return neither restores the saved context nor re-enables interrupts.
// R12: only one nesting level exists and no second interrupt is taken during service.
// R13: the status register at 00H holds request flag in bit 2, carry in bit 1, zero in bit 0, bit 3 reserved.
// R14: the control register at 09H holds the global enable in bit 1 and the pulse output enable in bit 0.
// R15: the request flag is set each time a pulse output cycle completes.
// R16: a request pending while the enable is low is taken on the clock after the enable returns.
module sliu_top
	import sliu_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire logic ce,
	input wire logic [4:0] reg_addr,
	input wire logic [3:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [3:0] reg_rdata,
	input wire logic [12:0] pc_next,
	input wire logic [3:0] program_page_high,
	input wire logic [3:0] memory_address_high,
	input wire logic alu_flag_we,
	input wire logic alu_carry,
	input wire logic alu_zero,
	input wire logic return_from_irq,
	output logic vector_load,
	output logic [12:0] vector_addr,
	output logic restore_load,
	output logic [12:0] restore_pc,
	output logic [3:0] restore_page_high,
	output logic [3:0] restore_mem_high,
	output logic carry_flag,
	output logic zero_flag,
	output logic pulse_irq_request_flag,
	output logic global_irq_enable,
	output logic pulse_output_enable,
	output logic pulse_cycle_done,
	output logic in_service,
	output logic irq
);

	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		sliu_state_t st;
		logic gie;
		logic pwm_en;
		logic flag;
		logic carry;
		logic zero;
		logic [9:0] div;
		logic tick;
		logic jump;
		logic [1:0] evt_sts;
		logic [1:0] evt_mask;
		logic [3:0] rdata;
	} sliu_regs_t;

	sliu_regs_t s_r;
	sliu_regs_t s_nxt;

	logic [22:0] ctx_rd;
	logic ctx_wr;
	logic take;
	logic wr_status;
	logic wr_ctrl;
	logic wr_evt_sts;
	logic wr_evt_mask;
	logic [1:0] evt_set;

	function automatic logic hit(input logic [4:0] a, input logic [4:0] ofs);
		hit = (a == ofs);
	endfunction

	// ****************************************
	// decode and acceptance
	// ****************************************
	assign wr_status = reg_wr && hit(reg_addr, SLIU_OFS_STATUS);
	assign wr_ctrl = reg_wr && hit(reg_addr, SLIU_OFS_CTRL);
	assign wr_evt_sts = reg_wr && hit(reg_addr, SLIU_OFS_EVT_STS);
	assign wr_evt_mask = reg_wr && hit(reg_addr, SLIU_OFS_EVT_MASK);

	// flag already pending and enable high: taken at this edge, so the
	// jump shows in the next cycle; a late enable just starts it later
	assign take = s_r.gie && s_r.flag && (s_r.st == SLIU_IDLE); // R3 R12 R16

	// context written in the same edge as the entry load
	assign ctx_wr = take; // R4 R5

	assign evt_set[SLIU_EV_REQ] = s_r.tick;
	assign evt_set[SLIU_EV_TAKEN] = take;

	sliu_ctx_store u_ctx (
		.clock(clock),
		.rst(rst),
		.ce(ce),
		.wr_en(ctx_wr),
		.wr_data({pc_next, program_page_high, memory_address_high,
			s_r.carry, s_r.zero}), // R4
		.rd_data(ctx_rd)
	);

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		s_nxt = s_r;
		s_nxt.jump = 1'b0;
		s_nxt.tick = 1'b0;

		// period counter stands in for the pulse output cycle
		if (s_r.pwm_en) begin
			if (s_r.div == SLIU_DIV_LAST) begin // R2
				s_nxt.div = SLIU_DIV_RST;
				s_nxt.tick = 1'b1;
			end else begin
				s_nxt.div = s_r.div + 10'h001;
			end
		end else begin
			s_nxt.div = SLIU_DIV_RST;
		end

		// core alu update of carry and zero
		if (alu_flag_we) begin
			s_nxt.carry = alu_carry;
			s_nxt.zero = alu_zero;
		end

		// software access to the status register
		if (wr_status) begin // R13
			s_nxt.flag = reg_wdata[SLIU_ST_FLAG];
			s_nxt.carry = reg_wdata[SLIU_ST_CARRY];
			s_nxt.zero = reg_wdata[SLIU_ST_ZERO];
		end

		// a completed cycle beats a clear in the same cycle
		if (s_r.tick) begin
			s_nxt.flag = 1'b1; // R15
		end

		if (wr_ctrl) begin // R14
			s_nxt.gie = reg_wdata[SLIU_CT_GIE];
			s_nxt.pwm_en = reg_wdata[SLIU_CT_PWM_EN];
		end

		unique case (s_r.st)
			SLIU_IDLE: begin
				if (take) begin
					s_nxt.st = SLIU_SERVICE;
					s_nxt.gie = 1'b0; // R6
					s_nxt.jump = 1'b1; // R1 R5
					// request flag left untouched for software
					s_nxt.flag = s_nxt.flag; // R7 R8
				end
			end
			SLIU_SERVICE: begin
				// no second acceptance until the return
				if (return_from_irq) begin // R11
					s_nxt.st = SLIU_IDLE;
					s_nxt.gie = 1'b1; // R10
					s_nxt.carry = ctx_rd[1]; // R9
					s_nxt.zero = ctx_rd[0]; // R9
				end
			end
		endcase

		// event bits: write one clears, a new event wins
		if (wr_evt_sts) begin
			s_nxt.evt_sts = s_r.evt_sts & ~reg_wdata[SLIU_EV_W-1:0];
		end
		s_nxt.evt_sts = s_nxt.evt_sts | evt_set;

		if (wr_evt_mask) begin
			s_nxt.evt_mask = reg_wdata[SLIU_EV_W-1:0];
		end

		// read data stands one cycle after the strobe only
		s_nxt.rdata = SLIU_RST_NIB;
		if (reg_rd) begin
			if (hit(reg_addr, SLIU_OFS_STATUS)) begin // R13
				s_nxt.rdata = {1'b0, s_r.flag, s_r.carry, s_r.zero};
			end else if (hit(reg_addr, SLIU_OFS_CTRL)) begin // R14
				s_nxt.rdata = {2'b00, s_r.gie, s_r.pwm_en};
			end else if (hit(reg_addr, SLIU_OFS_EVT_STS)) begin
				s_nxt.rdata = {2'b00, s_r.evt_sts};
			end else if (hit(reg_addr, SLIU_OFS_EVT_MASK)) begin
				s_nxt.rdata = {2'b00, s_r.evt_mask};
			end
		end
	end

	// ****************************************
	// registers
	// ****************************************
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			s_r.st <= SLIU_IDLE;
			s_r.gie <= SLIU_RST_GIE;
			s_r.pwm_en <= SLIU_RST_PWM_EN;
			s_r.flag <= SLIU_RST_FLAG;
			s_r.carry <= SLIU_RST_CARRY;
			s_r.zero <= SLIU_RST_ZERO;
			s_r.div <= SLIU_DIV_RST;
			s_r.tick <= 1'b0;
			s_r.jump <= 1'b0;
			s_r.evt_sts <= SLIU_RST_EVT;
			s_r.evt_mask <= SLIU_RST_EVT;
			s_r.rdata <= SLIU_RST_NIB;
		end else if (ce) begin
			s_r <= s_nxt;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign reg_rdata = s_r.rdata;
	assign vector_load = s_r.jump; // R1
	assign vector_addr = SLIU_IRQ_ENTRY; // R1
	// only the interrupt return restores; a plain return has no path here
	assign restore_load = return_from_irq && (s_r.st == SLIU_SERVICE) && ce; // R9 R11
	assign restore_pc = ctx_rd[22:10]; // R9
	assign restore_page_high = ctx_rd[9:6]; // R9
	assign restore_mem_high = ctx_rd[5:2]; // R9
	assign carry_flag = s_r.carry;
	assign zero_flag = s_r.zero;
	assign pulse_irq_request_flag = s_r.flag;
	assign global_irq_enable = s_r.gie;
	assign pulse_output_enable = s_r.pwm_en;
	assign pulse_cycle_done = s_r.tick;
	assign in_service = (s_r.st == SLIU_SERVICE);
	assign irq = |(s_r.evt_sts & s_r.evt_mask);

endmodule

`default_nettype wire

// >>> sim/sliu_checker.sv
// port assertions for the single-level interrupt unit
`timescale 1ns/1ps
`default_nettype none
module sliu_checker
	import sliu_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire logic ce,
	input wire logic [12:0] pc_next,
	input wire logic vector_load,
	input wire logic [12:0] vector_addr,
	input wire logic restore_load,
	input wire logic [12:0] restore_pc,
	input wire logic pulse_irq_request_flag,
	input wire logic global_irq_enable,
	input wire logic pulse_cycle_done,
	input wire logic in_service,
	input wire logic reg_wr,
	input wire logic [4:0] reg_addr,
	input wire logic reg_rd,
	input wire logic [3:0] reg_rdata
);
	// a status write in the accept cycle may clear the flag legally
	logic st_wr;
	assign st_wr = reg_wr && (reg_addr == SLIU_OFS_STATUS);
	// ****************************************
	// entry, return, flag and read data relations
	// ****************************************
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	a_entry_addr: assert property (vector_load |-> vector_addr == 13'h0008)
		else $error("wrong entry address");
	a_accept_next: assert property (global_irq_enable && pulse_irq_request_flag
		&& !in_service && ce |=> vector_load && in_service) else $error("request not taken");
	a_no_accept_off: assert property (!global_irq_enable |=> !vector_load)
		else $error("taken while disabled");
	a_entry_clears_gie: assert property (vector_load |-> !global_irq_enable)
		else $error("enable not cleared");
	a_flag_kept: assert property (vector_load && !$past(st_wr) |-> pulse_irq_request_flag)
		else $error("flag cleared by entry");
	a_save_pc: assert property (vector_load |-> restore_pc == $past(pc_next))
		else $error("pc not saved");
	a_return_state: assert property (restore_load |=> global_irq_enable && !in_service)
		else $error("return incomplete");
	a_no_nesting: assert property (in_service && !restore_load |=> !vector_load)
		else $error("nested entry");
	a_tick_sets_flag: assert property (pulse_cycle_done && ce |=> pulse_irq_request_flag)
		else $error("tick lost");
	a_rdata_idle: assert property (!reg_rd && ce |=> reg_rdata == 4'h0)
		else $error("read data outside slot");
	c_entry: cover property (vector_load);
	c_return: cover property (restore_load);
	c_tick: cover property (pulse_cycle_done);
endmodule
bind sliu_top sliu_checker sliu_checker_inst (.*);
`default_nettype wire

// >>> sim/sliu_core_model.sv
// program counter model of the core beside the interrupt unit
`timescale 1ns/1ps
`default_nettype none
module sliu_core_model (
	input wire logic clock,
	input wire logic rst,
	input wire logic vector_load,
	input wire logic [12:0] vector_addr,
	input wire logic restore_load,
	input wire logic [12:0] restore_pc,
	output logic [12:0] pc_next,
	output logic [12:0] pc_r
);
	// ****************************************
	// pc stepping
	// ****************************************
	// return wins: the unit raises both if return_from_irq comes in the first service cycle
	always_ff @(posedge clock or posedge rst) begin
		if (rst) pc_r <= 13'h0000;
		else if (restore_load) pc_r <= restore_pc;
		else if (vector_load) pc_r <= vector_addr;
		else pc_r <= pc_r + 13'h0001;
	end
	assign pc_next = pc_r + 13'h0001;
endmodule
`default_nettype wire

// >>> sim/sliu_top_tb_top.sv
// self-checking bench for the single-level interrupt unit
`timescale 1ns/1ps
`default_nettype none
module sliu_top_tb_top
	import sliu_pkg::*;
;
	logic clock, rst, ce, reg_wr, reg_rd, alu_flag_we, alu_carry, alu_zero, return_from_irq;
	logic [4:0] reg_addr;
	logic [3:0] reg_wdata, reg_rdata, program_page_high, memory_address_high;
	logic [3:0] restore_page_high, restore_mem_high;
	logic [12:0] pc_next, pc_r, prev_pc, saved, vector_addr, restore_pc;
	logic vector_load, restore_load, carry_flag, zero_flag, pulse_irq_request_flag;
	logic global_irq_enable, pulse_output_enable, pulse_cycle_done, in_service, irq;
	int bad_count, checks, n;
	sliu_top sliu_top_inst (.*);
	sliu_core_model sliu_core_model_inst (.*);
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	always @(posedge clock) prev_pc <= pc_next;
	// ****************************************
	// access tasks
	// ****************************************
	task automatic chk1(input string nm, input logic e, input logic g);
		checks++;
		if (g !== e) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chkv(input string nm, input logic [12:0] e, input logic [12:0] g);
		checks++;
		if (g !== e) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [3:0] d);
		@(posedge clock);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_wr <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [4:0] a, input logic [3:0] e);
		@(posedge clock);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1;
		chkv("rdata", 13'(e), 13'(reg_rdata));
	endtask
	task automatic alu(input logic c, input logic z);
		@(posedge clock);
		alu_flag_we <= 1'b1;
		alu_carry <= c;
		alu_zero <= z;
		@(posedge clock);
		alu_flag_we <= 1'b0;
	endtask
	// bounded wait: k 0 entry pulse, 1 period tick; n counts cycles
	task automatic wait_ev(input int k);
		logic s;
		n = 0;
		do begin
			@(posedge clock);
			#1;
			n++;
			s = (k == 0) ? vector_load : pulse_cycle_done;
		end while (s !== 1'b1 && n < 2000);
		if (s !== 1'b1) begin
			chk1("wait", 1'b1, s);
			end_sim();
		end
	endtask
	task automatic end_sim;
		$display("checks %0d bad_count %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// ****************************************
	// test sequence
	// ****************************************
	initial begin
		{rst, ce} = 2'b11;
		{reg_wr, reg_rd, alu_flag_we, alu_carry, alu_zero, return_from_irq} = 6'h00;
		reg_addr = 5'h00;
		reg_wdata = 4'h0;
		program_page_high = 4'hA;
		memory_address_high = 4'h5;
		repeat (6) @(posedge clock);
		rst <= 1'b0;
		rd(SLIU_OFS_STATUS, 4'h0);
		rd(SLIU_OFS_CTRL, 4'h0);
		rd(5'h1F, 4'h0);
		wr(SLIU_OFS_STATUS, 4'hB);
		rd(SLIU_OFS_STATUS, 4'h3);
		$display("test registers done");
		wr(SLIU_OFS_STATUS, 4'h4);
		alu(1'b1, 1'b0);
		repeat (3) @(posedge clock);
		#1;
		chk1("pending", 1'b0, vector_load);
		wr(SLIU_OFS_CTRL, 4'h2);
		wait_ev(0);
		saved = prev_pc;
		chkv("delay", 13'h0001, 13'(n));
		chkv("vector", 13'h0008, vector_addr);
		chk1("gie", 1'b0, global_irq_enable);
		chk1("flag", 1'b1, pulse_irq_request_flag);
		chkv("saved pc", saved, restore_pc);
		program_page_high <= 4'h3;
		memory_address_high <= 4'hC;
		alu(1'b0, 1'b1);
		wr(SLIU_OFS_CTRL, 4'h2);
		repeat (2) @(posedge clock);
		#1;
		chk1("nest", 1'b0, vector_load);
		chk1("plain return", 1'b0, restore_load);
		wr(SLIU_OFS_CTRL, 4'h0);
		wr(SLIU_OFS_STATUS, 4'h1);
		chk1("gie off", 1'b0, global_irq_enable);
		@(posedge clock);
		return_from_irq <= 1'b1;
		#1;
		chk1("restore", 1'b1, restore_load);
		chkv("page", 13'h000A, 13'(restore_page_high));
		chkv("mah", 13'h0005, 13'(restore_mem_high));
		@(posedge clock);
		return_from_irq <= 1'b0;
		#1;
		chk1("gie", 1'b1, global_irq_enable);
		chk1("service", 1'b0, in_service);
		chkv("cz", 13'h0002, 13'({carry_flag, zero_flag}));
		chkv("pc", saved, pc_r);
		$display("test entry and return done");
		wr(SLIU_OFS_EVT_MASK, 4'h2);
		chk1("irq", 1'b1, irq);
		wr(SLIU_OFS_EVT_STS, 4'h3);
		chk1("irq", 1'b0, irq);
		rd(SLIU_OFS_EVT_STS, 4'h0);
		ce <= 1'b0;
		wr(SLIU_OFS_STATUS, 4'h4);
		ce <= 1'b1;
		rd(SLIU_OFS_STATUS, 4'h2);
		$display("test events done");
		wr(SLIU_OFS_CTRL, 4'hD);
		rd(SLIU_OFS_CTRL, 4'h1);
		chk1("pwm en", 1'b1, pulse_output_enable);
		wait_ev(1);
		wait_ev(1);
		chkv("period", 13'(SLIU_DIV_CYCLES), 13'(n));
		@(posedge clock);
		#1;
		chk1("flag", 1'b1, pulse_irq_request_flag);
		rd(SLIU_OFS_EVT_STS, 4'h1);
		chk1("irq masked", 1'b0, irq);
		$display("test period done");
		end_sim();
	end
endmodule
`default_nettype wire
